// file: verilog/tcr_params.svh
// constants of the 16-bit capture/reload/baud timer
`ifndef TCR_PARAMS_SVH
`define TCR_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TCR_OFS_CLOCK_CONTROL  8'h8e
`define TCR_OFS_CONTROL        8'hc8
`define TCR_OFS_MODE           8'hc9
`define TCR_OFS_RELOAD_LOW     8'hca
`define TCR_OFS_RELOAD_HIGH    8'hcb
`define TCR_OFS_COUNT_LOW      8'hcc
`define TCR_OFS_COUNT_HIGH     8'hcd
`define TCR_OFS_POWER_MODE     8'hc4

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TCR_CTL_OVF_FLAG       7
`define TCR_CTL_EXT_FLAG       6
`define TCR_CTL_RX_BAUD        5
`define TCR_CTL_TX_BAUD        4
`define TCR_CTL_TRIG_EN        3
`define TCR_CTL_RUN            2
`define TCR_CTL_SRC_SEL        1
`define TCR_CTL_CAP_SEL        0
`define TCR_MOD_CLK_OUT_EN     1
`define TCR_MOD_DOWN_EN        0
`define TCR_CKC_PRESCALE_SEL   5
`define TCR_PWR_MODE_ONE       0
`define TCR_PWR_MODE_TWO       1

// ----------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------
`define TCR_RST_BYTE           8'h00
`define TCR_RST_WORD           16'h0000
`define TCR_MOD_MASK           8'h03
`define TCR_PWR_MASK           8'h03
`define TCR_ALL_ONES           16'hffff

// ----------------------------------------------------------------
// oscillator clocks per tick and power mode factors
// ----------------------------------------------------------------
`define TCR_DIV_STD            12'd12
`define TCR_DIV_FAST           12'd4
`define TCR_DIV_BAUD           12'd2
`define TCR_PM1_FACTOR         12'd16
`define TCR_PM2_FACTOR         12'd256

`endif

// file: verilog/tcr_pkg.sv
// types of the 16-bit capture/reload/baud timer
package tcr_pkg;

	// time base chosen for the internal tick
	typedef enum logic [1:0]
	{
		TCR_BASE_STD  = 2'b00,
		TCR_BASE_FAST = 2'b01,
		TCR_BASE_BAUD = 2'b10
	} tcr_base_t;

	// power management divider
	typedef enum logic [1:0]
	{
		TCR_PM_NONE = 2'b00,
		TCR_PM_ONE  = 2'b01,
		TCR_PM_TWO  = 2'b10
	} tcr_pm_t;

endpackage

// file: verilog/tcr_timer2.sv
// 16-bit timer with capture, auto-reload, baud and clock-out modes
//
// Behaviour
// - always one plain 16-bit counter
// - source select counts pin falls or ticks
// - internal tick is oscillator over 12 or 4
// - counts only while run control set
// - wrap to zero sets overflow flag
// - trigger fall captures count into reload
// - select bit picks capture or auto-reload
// - overflow reloads count from reload pair
// - enabled trigger fall forces reload
// - down enable: trigger pin sets direction
// - down match of reload loads all ones
// - up/down wraps toggle external flag
// - baud select forces reload, feeds serial
// - baud mode trigger fall sets external flag
// - baud and clock-out tick is oscillator/2
// - clock-out toggles count pin on overflow
// - clock-out raises no overflow flag
// - reset default is twelve clocks per tick
// - power modes divide by 16 or 256
// - baud modes under power: 32 or 512
// - writing one to external flag sets it
`timescale 1ns/1ps
`include "tcr_params.svh"

module tcr_timer2
(
	// clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        SRST,
	// register port
	input  wire logic [7:0]  ADDR,
	input  wire logic [7:0]  WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [7:0]  RDATA,
	// count pin, two-way
	input  wire logic        COUNT_PIN_I,
	output logic             COUNT_PIN_O,
	output logic             COUNT_PIN_OE,
	// trigger pin
	input  wire logic        TRIG_PIN,
	// serial port clocks and interrupt request
	output logic             RX_BAUD_TICK,
	output logic             TX_BAUD_TICK,
	output logic             TIMER_IRQ
);

	// ------------------------------------------------------------
	// divider arithmetic
	// ------------------------------------------------------------
	// clocks per tick, minus one, for a base and a power mode
	function automatic logic [11:0] div_last
	(
		input tcr_pkg::tcr_base_t base,
		input tcr_pkg::tcr_pm_t   pm
	);
		logic [11:0] d;
		d = `TCR_DIV_STD;
		case (base)
			tcr_pkg::TCR_BASE_STD:  d = `TCR_DIV_STD;
			tcr_pkg::TCR_BASE_FAST: d = `TCR_DIV_FAST;
			tcr_pkg::TCR_BASE_BAUD: d = `TCR_DIV_BAUD;
			default:                d = `TCR_DIV_STD;
		endcase
		case (pm)
			tcr_pkg::TCR_PM_ONE: d = 12'(d * `TCR_PM1_FACTOR);
			tcr_pkg::TCR_PM_TWO: d = 12'(d * `TCR_PM2_FACTOR);
			default:             d = d;
		endcase
		return 12'(d - 12'd1);
	endfunction

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0]  ckc_r;
	logic [7:0]  ctl_r;
	logic [7:0]  mod_r;
	logic [7:0]  pwr_r;
	logic [15:0] cnt_r;
	logic [15:0] rld_r;
	logic [11:0] presc_r;
	logic        cnt_meta_r;
	logic        cnt_sync_r;
	logic        cnt_prev_r;
	logic        trg_meta_r;
	logic        trg_sync_r;
	logic        trg_prev_r;
	logic        pin_out_r;
	logic        pin_oe_r;
	logic [7:0]  rdata_r;
	logic        rx_tick_r;
	logic        tx_tick_r;
	logic        irq_r;

	// ------------------------------------------------------------
	// decoding
	// ------------------------------------------------------------
	wire wr_ckc = WR && (ADDR == `TCR_OFS_CLOCK_CONTROL);
	wire wr_ctl = WR && (ADDR == `TCR_OFS_CONTROL);
	wire wr_mod = WR && (ADDR == `TCR_OFS_MODE);
	wire wr_pwr = WR && (ADDR == `TCR_OFS_POWER_MODE);
	wire wr_rll = WR && (ADDR == `TCR_OFS_RELOAD_LOW);
	wire wr_rlh = WR && (ADDR == `TCR_OFS_RELOAD_HIGH);
	wire wr_cnl = WR && (ADDR == `TCR_OFS_COUNT_LOW);
	wire wr_cnh = WR && (ADDR == `TCR_OFS_COUNT_HIGH);

	wire ovf_flag  = ctl_r[`TCR_CTL_OVF_FLAG];
	wire ext_flag  = ctl_r[`TCR_CTL_EXT_FLAG];
	wire rx_baud   = ctl_r[`TCR_CTL_RX_BAUD];
	wire tx_baud   = ctl_r[`TCR_CTL_TX_BAUD];
	wire trig_en   = ctl_r[`TCR_CTL_TRIG_EN];
	wire run       = ctl_r[`TCR_CTL_RUN];
	wire src_pin   = ctl_r[`TCR_CTL_SRC_SEL];
	wire cap_sel   = ctl_r[`TCR_CTL_CAP_SEL];
	wire clk_oe    = mod_r[`TCR_MOD_CLK_OUT_EN];
	wire down_en   = mod_r[`TCR_MOD_DOWN_EN];

	// baud select overrides the capture choice
	wire baud_mode = rx_baud | tx_baud;
	wire rld_mode  = baud_mode | ~cap_sel;
	wire cap_mode  = ~rld_mode;
	wire clko_mode = clk_oe & rld_mode & ~src_pin;
	wire updn_mode = down_en & rld_mode & ~baud_mode;

	// ------------------------------------------------------------
	// time base
	// ------------------------------------------------------------
	wire tcr_pkg::tcr_base_t base_sel =
		(baud_mode | clko_mode) ? tcr_pkg::TCR_BASE_BAUD :
		ckc_r[`TCR_CKC_PRESCALE_SEL] ? tcr_pkg::TCR_BASE_FAST :
		tcr_pkg::TCR_BASE_STD;
	wire tcr_pkg::tcr_pm_t pm_sel =
		pwr_r[`TCR_PWR_MODE_TWO] ? tcr_pkg::TCR_PM_TWO :
		pwr_r[`TCR_PWR_MODE_ONE] ? tcr_pkg::TCR_PM_ONE :
		tcr_pkg::TCR_PM_NONE;
	wire [11:0] presc_last = div_last(base_sel, pm_sel);
	// >= keeps the divider from running away when the rate shrinks
	wire        tick       = run && (presc_r >= presc_last);
	wire [11:0] presc_nxt  =
		(!run || tick) ? 12'h000 : 12'(presc_r + 12'h001);

	// ------------------------------------------------------------
	// pin edges
	// ------------------------------------------------------------
	// edges come from the synchronised and delayed copies only
	wire cnt_fall = cnt_prev_r & ~cnt_sync_r;
	wire trg_fall = trg_prev_r & ~trg_sync_r;
	wire trg_evt  = trig_en & trg_fall;

	// ------------------------------------------------------------
	// counting
	// ------------------------------------------------------------
	// the pin path ignores prescale and power divide; the source
	// must stay below an eighth of the clock for clean edges
	wire step    = run && (src_pin ? cnt_fall : tick);
	wire go_down = updn_mode & ~trg_sync_r;
	wire at_top  = (cnt_r == `TCR_ALL_ONES);
	wire at_rld  = (cnt_r == rld_r);
	wire ovf_evt = step & ~go_down & at_top;
	wire udf_evt = step & go_down & at_rld;
	wire wrap    = ovf_evt | udf_evt;
	// in up/down mode the trigger steers direction, not reloads
	wire force_rld = trg_evt & rld_mode & ~updn_mode & ~baud_mode;
	wire do_cap    = trg_evt & cap_mode;

	logic [15:0] cnt_step;
	always_comb
	begin
		cnt_step = cnt_r;
		if (udf_evt)
			cnt_step = `TCR_ALL_ONES;
		else if (ovf_evt && rld_mode)
			cnt_step = rld_r;
		else if (go_down && step)
			cnt_step = 16'(cnt_r - 16'h0001);
		else if (step)
			cnt_step = 16'(cnt_r + 16'h0001);
	end

	// software writes to the count win over the step; in baud
	// mode software keeps away from them while running
	wire [15:0] cnt_base = force_rld ? rld_r : cnt_step;
	wire [15:0] cnt_nxt  = {wr_cnh ? WDATA : cnt_base[15:8],
		wr_cnl ? WDATA : cnt_base[7:0]};

	wire [15:0] rld_nxt  = {wr_rlh ? WDATA :
		(do_cap ? cnt_r[15:8] : rld_r[15:8]),
		wr_rll ? WDATA :
		(do_cap ? cnt_r[7:0] : rld_r[7:0])};

	// ------------------------------------------------------------
	// flags
	// ------------------------------------------------------------
	// hardware set wins over a software clear in the same cycle
	wire ovf_set = wrap & ~baud_mode & ~clko_mode;
	wire ovf_nxt = ovf_set |
		(wr_ctl ? WDATA[`TCR_CTL_OVF_FLAG] : ovf_flag);
	wire ext_tgl = wrap & updn_mode;
	wire ext_set = (trg_evt & ~updn_mode);
	wire ext_wr  = wr_ctl ? WDATA[`TCR_CTL_EXT_FLAG] : ext_flag;
	wire ext_nxt = ext_tgl ? ~ext_flag :
		(ext_set | ext_wr);
	wire [7:0] ctl_low = wr_ctl ? WDATA : ctl_r;
	wire [7:0] ctl_nxt = {ovf_nxt, ext_nxt, ctl_low[5:0]};

	// ------------------------------------------------------------
	// clock-out pin and serial clocks
	// ------------------------------------------------------------
	wire pin_nxt = (clko_mode && run && wrap) ? ~pin_out_r
		: pin_out_r;
	wire rx_nxt  = wrap & rx_baud;
	wire tx_nxt  = wrap & tx_baud;
	wire irq_nxt = ovf_nxt | ext_nxt;

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	wire [7:0] rd_mux =
		(ADDR == `TCR_OFS_CLOCK_CONTROL) ? ckc_r :
		(ADDR == `TCR_OFS_CONTROL)       ? ctl_r :
		(ADDR == `TCR_OFS_MODE)          ? mod_r :
		(ADDR == `TCR_OFS_POWER_MODE)    ? pwr_r :
		(ADDR == `TCR_OFS_RELOAD_LOW)    ? rld_r[7:0] :
		(ADDR == `TCR_OFS_RELOAD_HIGH)   ? rld_r[15:8] :
		(ADDR == `TCR_OFS_COUNT_LOW)     ? cnt_r[7:0] :
		(ADDR == `TCR_OFS_COUNT_HIGH)    ? cnt_r[15:8] :
		`TCR_RST_BYTE;
	wire [7:0] rdata_nxt = RD ? rd_mux : `TCR_RST_BYTE;

	// ------------------------------------------------------------
	// synchronisers
	// ------------------------------------------------------------
	// reset to the idle high level so no false fall follows reset
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			cnt_meta_r <= 1'b1;
			cnt_sync_r <= 1'b1;
			cnt_prev_r <= 1'b1;
		end
		else
		begin
			cnt_meta_r <= COUNT_PIN_I;
			cnt_sync_r <= cnt_meta_r;
			cnt_prev_r <= cnt_sync_r;
		end
	end

	// the synced trigger level also steers the count direction
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			trg_meta_r <= 1'b1;
			trg_sync_r <= 1'b1;
			trg_prev_r <= 1'b1;
		end
		else
		begin
			trg_meta_r <= TRIG_PIN;
			trg_sync_r <= trg_meta_r;
			trg_prev_r <= trg_sync_r;
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			ckc_r <= `TCR_RST_BYTE;
			mod_r <= `TCR_RST_BYTE;
			pwr_r <= `TCR_RST_BYTE;
			ctl_r <= `TCR_RST_BYTE;
		end
		else
		begin
			if (wr_ckc)
				ckc_r <= WDATA;
			if (wr_mod)
				mod_r <= WDATA & `TCR_MOD_MASK;
			if (wr_pwr)
				pwr_r <= WDATA & `TCR_PWR_MASK;
			ctl_r <= ctl_nxt;
		end
	end

	// ------------------------------------------------------------
	// counter and reload pair
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			cnt_r   <= `TCR_RST_WORD;
			rld_r   <= `TCR_RST_WORD;
			presc_r <= 12'h000;
		end
		else
		begin
			cnt_r   <= cnt_nxt;
			rld_r   <= rld_nxt;
			presc_r <= presc_nxt;
		end
	end

	// ------------------------------------------------------------
	// clock-out pin
	// ------------------------------------------------------------
	// the pin idles high, so turning the driver on starts from the
	// same level as the pulled-up input
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			pin_out_r <= 1'b1;
			pin_oe_r  <= 1'b0;
		end
		else
		begin
			pin_out_r <= pin_nxt;
			pin_oe_r  <= clk_oe;
		end
	end

	// ------------------------------------------------------------
	// serial clocks and interrupt request
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			rx_tick_r <= 1'b0;
			tx_tick_r <= 1'b0;
			irq_r     <= 1'b0;
		end
		else
		begin
			rx_tick_r <= rx_nxt;
			tx_tick_r <= tx_nxt;
			irq_r     <= irq_nxt;
		end
	end

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	// read data stand one cycle only and read zero otherwise
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			rdata_r <= `TCR_RST_BYTE;
		else
			rdata_r <= rdata_nxt;
	end

	assign RDATA        = rdata_r;
	assign COUNT_PIN_O  = pin_out_r;
	assign COUNT_PIN_OE = pin_oe_r;
	assign RX_BAUD_TICK = rx_tick_r;
	assign TX_BAUD_TICK = tx_tick_r;
	assign TIMER_IRQ    = irq_r;

endmodule

// file: tb/tcr_timer2_checker.sv
// port assertions of the 16-bit timer
`timescale 1ns/1ps

module tcr_timer2_checker
(
	// clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        SRST,
	// register port
	input  wire logic [7:0]  ADDR,
	input  wire logic [7:0]  WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	input  wire logic [7:0]  RDATA,
	// pins and outputs
	input  wire logic        COUNT_PIN_I,
	input  wire logic        COUNT_PIN_O,
	input  wire logic        COUNT_PIN_OE,
	input  wire logic        TRIG_PIN,
	input  wire logic        RX_BAUD_TICK,
	input  wire logic        TX_BAUD_TICK,
	input  wire logic        TIMER_IRQ
);
	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	wire logic wr_ctl;
	wire logic wr_mod;
	assign wr_ctl = WR && ADDR == 8'hc8;
	assign wr_mod = WR && ADDR == 8'hc9;

	default clocking dc @(posedge REF_CLK); endclocking
	default disable iff (SRST);

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_irq_hold: assert property (
		TIMER_IRQ && !wr_ctl |=> TIMER_IRQ)
		else $error("irq dropped without a control write");
	// three quiet cycles let a tick from an old wrap drain out
	a_rx_off: assert property (
		wr_ctl && !WDATA[5] ##1 !wr_ctl [*3] |-> !RX_BAUD_TICK)
		else $error("rx tick while rx baud is off");
	a_tx_off: assert property (
		wr_ctl && !WDATA[4] ##1 !wr_ctl [*3] |-> !TX_BAUD_TICK)
		else $error("tx tick while tx baud is off");
	a_rx_gap: assert property (
		RX_BAUD_TICK |=> !RX_BAUD_TICK)
		else $error("rx ticks faster than two clocks");
	a_tx_gap: assert property (
		TX_BAUD_TICK |=> !TX_BAUD_TICK)
		else $error("tx ticks faster than two clocks");
	a_pin_gap: assert property (
		$changed(COUNT_PIN_O) |=> $stable(COUNT_PIN_O))
		else $error("clock out toggled twice in a row");
	a_oe_follow: assert property (
		wr_mod ##1 !wr_mod [*2] |-> COUNT_PIN_OE == $past(WDATA[1], 2))
		else $error("pin enable does not follow mode write");
	a_reset_quiet: assert property (
		disable iff (1'b0) SRST |=> !TIMER_IRQ && COUNT_PIN_O
		&& !COUNT_PIN_OE && RDATA == 8'h00)
		else $error("outputs not at reset values");
endmodule

// file: tb/tcr_pin_model.sv
// count and trigger pin drivers outside the timer
`timescale 1ns/1ps

module tcr_pin_model
(
	// clock
	input  wire logic  clk,
	// pins
	input  wire logic  cnt_o,
	input  wire logic  cnt_oe,
	output logic       cnt_i,
	output logic       trig
);
	logic src;

	// pull-up: pin idles high, the timer wins while enabled
	assign cnt_i = cnt_oe ? cnt_o : src;
	initial src = 1'b1;
	initial trig = 1'b1;

	// one fall per eight clocks, the fastest rate allowed
	task automatic pulse(input int n);
		repeat (n)
		begin
			@(posedge clk);
			src <= 1'b0;
			repeat (4) @(posedge clk);
			src <= 1'b1;
			repeat (3) @(posedge clk);
		end
	endtask

	// level held long enough to pass the synchroniser
	task automatic level(input logic v);
		@(posedge clk);
		trig <= v;
		repeat (4) @(posedge clk);
	endtask
endmodule

// file: tb/tb_tcr_timer2.sv
// self-checking bench of the 16-bit timer
`timescale 1ns/1ps

module tb_tcr_timer2;
	logic        ref_clk = 1'b0;
	logic        srst = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  rdata;
	logic        cnt_i;
	logic        cnt_o;
	logic        cnt_oe;
	logic        trig;
	logic        rx_tick;
	logic        tx_tick;
	logic        irq;
	int          num_errors = 0;
	int          comparisons = 0;

	always #5 ref_clk = ~ref_clk;

	tcr_timer2 i_tcr_timer2 (.REF_CLK(ref_clk), .SRST(srst), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.COUNT_PIN_I(cnt_i), .COUNT_PIN_O(cnt_o), .COUNT_PIN_OE(cnt_oe),
		.TRIG_PIN(trig), .RX_BAUD_TICK(rx_tick), .TX_BAUD_TICK(tx_tick),
		.TIMER_IRQ(irq));
	tcr_pin_model i_tcr_pin_model (.clk(ref_clk), .cnt_o(cnt_o),
		.cnt_oe(cnt_oe), .cnt_i(cnt_i), .trig(trig));

	// ------------------------------------------------------------
	// bus and compare tasks
	// ------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask
	// count and reload are written while stopped, except the second count load in t_wrap, which lands while running
	task automatic w16(input logic [7:0] a, input logic [15:0] d);
		wreg(a, d[7:0]);
		wreg(a + 8'h01, d[15:8]);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 check(rdata, e);
	endtask
	task automatic fall;
		i_tcr_pin_model.level(1'b0);
		i_tcr_pin_model.level(1'b1);
	endtask
	function automatic logic [7:0] near(input int k, input int e);
		return {7'h00, k >= e - 1 && k <= e + 1};
	endfunction

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		logic [7:0] a [9] = '{8'h8e, 8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hcc,
			8'hcd, 8'hc4, 8'h00};
		foreach (a[i])
			rchk(a[i], 8'h00);
		wreg(8'hc9, 8'hff);
		rchk(8'hc9, 8'h03);
		wreg(8'hc9, 8'h00);
	endtask
	// n + 2 clocks of run, so the tick count never sits on a boundary
	task automatic t_run(input logic [7:0] ck, input logic [7:0] pm,
		input int n, input logic [7:0] e);
		wreg(8'h8e, ck);
		wreg(8'hc4, pm);
		w16(8'hcc, 16'h0000);
		wreg(8'hc8, 8'h05);
		repeat (n) @(posedge ref_clk);
		wreg(8'hc8, 8'h01);
		rchk(8'hcc, e);
		repeat (30) @(posedge ref_clk);
		rchk(8'hcc, e);
	endtask
	task automatic t_wrap;
		w16(8'hca, 16'h1234);
		w16(8'hcc, 16'hfffe);
		wreg(8'hc8, 8'h04);
		repeat (20) @(posedge ref_clk);
		rchk(8'hcd, 8'h12);
		rchk(8'hc8, 8'h84);
		w16(8'hcc, 16'hfffe);
		wreg(8'hc8, 8'h05);
		repeat (20) @(posedge ref_clk);
		rchk(8'hc8, 8'h85);
		check({7'h00, irq}, 8'h01);
		wreg(8'hc8, 8'h01);
		@(negedge ref_clk);
		check({7'h00, irq}, 8'h00);
		wreg(8'hc8, 8'h40);
		rchk(8'hc8, 8'h40);
		check({7'h00, irq}, 8'h01);
		wreg(8'hc8, 8'h00);
	endtask
	task automatic t_trig;
		w16(8'hcc, 16'habcd);
		wreg(8'hc8, 8'h09);
		fall;
		rchk(8'hca, 8'hcd);
		rchk(8'hcb, 8'hab);
		rchk(8'hc8, 8'h49);
		wreg(8'hc8, 8'h00);
		w16(8'hcc, 16'h0005);
		fall;
		rchk(8'hcc, 8'h05);
		rchk(8'hc8, 8'h00);
		wreg(8'hc8, 8'h08);
		fall;
		rchk(8'hcc, 8'hcd);
		rchk(8'hc8, 8'h48);
		wreg(8'hc8, 8'h00);
	endtask
	task automatic t_updown;
		wreg(8'hc9, 8'h01);
		w16(8'hca, 16'h0010);
		w16(8'hcc, 16'h0012);
		i_tcr_pin_model.level(1'b0);
		wreg(8'hc8, 8'h04);
		repeat (20) @(posedge ref_clk);
		rchk(8'hcd, 8'hff);
		rchk(8'hc8, 8'hc4);
		wreg(8'hc8, 8'h00);
		wreg(8'hc9, 8'h00);
		i_tcr_pin_model.level(1'b1);
		w16(8'hcc, 16'h0000);
		wreg(8'hc8, 8'h07);
		i_tcr_pin_model.pulse(5);
		rchk(8'hcc, 8'h05);
		wreg(8'hc8, 8'h00);
	endtask
	// baud and clock-out together; reload fffe wraps every two ticks
	task automatic t_baud(input logic [7:0] pm, input int n, input int e);
		int rx;
		int tx;
		int tg;
		logic p;
		rx = 0;
		tx = 0;
		tg = 0;
		wreg(8'hc4, pm);
		w16(8'hca, 16'hfffe);
		w16(8'hcc, 16'hfffe);
		wreg(8'hc9, 8'h02);
		wreg(8'hc8, 8'h3c);
		p = cnt_o;
		repeat (n)
		begin
			@(negedge ref_clk);
			rx += rx_tick;
			tx += tx_tick;
			tg += (cnt_o !== p);
			p = cnt_o;
		end
		check(near(rx, e), 8'h01);
		check(near(tx, e), 8'h01);
		check(near(tg, e), 8'h01);
		check({6'h00, cnt_oe, irq}, 8'h02);
		rchk(8'hc8, 8'h3c);
		fall;
		rchk(8'hc8, 8'h7c);
		wreg(8'hc8, 8'h00);
		wreg(8'hc9, 8'h00);
	endtask

	// ------------------------------------------------------------
	// run control
	// ------------------------------------------------------------
	task automatic end_of_test;
		if (num_errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		repeat (20) @(posedge ref_clk);
		srst <= 1'b0;
		t_regs;
		t_run(8'h00, 8'h00, 124, 8'h0a);
		t_run(8'h20, 8'h00, 40, 8'h0a);
		t_run(8'h20, 8'h01, 643, 8'h0a);
		t_run(8'h20, 8'h02, 2558, 8'h02);
		wreg(8'hc4, 8'h00);
		t_wrap;
		t_trig;
		t_updown;
		t_baud(8'h00, 80, 20);
		t_baud(8'h01, 640, 10);
		end_of_test;
	end

	initial
	begin
		#500000;
		num_errors++;
		end_of_test;
	end
endmodule

bind tcr_timer2 tcr_timer2_checker i_tcr_timer2_checker (.REF_CLK(REF_CLK),
	.SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
	.RDATA(RDATA), .COUNT_PIN_I(COUNT_PIN_I), .COUNT_PIN_O(COUNT_PIN_O),
	.COUNT_PIN_OE(COUNT_PIN_OE), .TRIG_PIN(TRIG_PIN),
	.RX_BAUD_TICK(RX_BAUD_TICK), .TX_BAUD_TICK(TX_BAUD_TICK),
	.TIMER_IRQ(TIMER_IRQ));
